// ==== bcc_pkg.sv ====
// Contract
// - Range one setpoint is 0.4 V plus code times 1.25 mV.
// - Range two setpoint is 0.4 V plus code times 2.5 mV.
// - Range three setpoint is 0.4 V plus code times 5 mV.
// - Range four setpoint is 0.8 V plus code times 10 mV.
// - Setpoint reset value follows start-voltage strap sampled at power-up.
// - Writing one to control bit 7 resets all registers; bit reads zero.
// - Control bit 6 enables spread-spectrum clocking, reset zero.
// - Control bit 5, reset one, gates switching; registers retained when clear.
// - Forced PWM when control bit 4 set or mode pin high or synced.
// - Control bit 3, reset one, enables active output discharge.
// - Ramp field bits 1-0 select slew 10, 5, 1.25, 0.5 mV/us; reset 10b.
// - Primary control at offset 1h resets to 2Ah.
// - Range register bits 7-4 are read-only zero; host writes zeros.
// - Range field bits 3-2 select one of four output ranges; reset 10b.
// - Soft-start bits 1-0 select 0.5, 1, 2, 4 ms; reset 01b.
// - Range and soft-start register at 2h resets to 9h.
// - Auxiliary control at 3h resets to zero.
// - I2C target with 7-bit addressing only; no general call response.
// - Register write applies at the falling edge of the data-byte acknowledge.
// - Reads of unmapped offsets return 0x00.
// - Status flags record events since last read; reading clears them.
package bcc_pkg;
	localparam logic [7:0] OFS_SETPOINT = 8'h00;
	localparam logic [7:0] OFS_PRIMARY = 8'h01;
	localparam logic [7:0] OFS_RANGE = 8'h02;
	localparam logic [7:0] OFS_AUX = 8'h03;
	localparam logic [7:0] OFS_FLAGS = 8'h04;
	localparam logic [7:0] RST_PRIMARY = 8'h2a;
	localparam logic [7:0] RST_RANGE = 8'h09;
	localparam logic [7:0] RST_AUX = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h02;
	localparam logic [7:0] MASK_PRIMARY_RD = 8'h7f;
	localparam logic [7:0] MASK_RANGE = 8'h0f;
	localparam logic [7:0] MASK_AUX = 8'h03;
	localparam logic [7:0] MASK_FLAGS = 8'h3f;
	localparam int BIT_SOFT_RESET = 7;
	localparam int BIT_SPREAD = 6;
	localparam int BIT_SWITCH = 5;
	localparam int BIT_FPWM = 4;
	localparam int BIT_DISCH = 3;
	localparam int BIT_RETRY = 2;
	localparam int BIT_RAMP_LO = 0;
	localparam int BIT_RANGE_LO = 2;
	localparam int BIT_SS_LO = 0;
	// Strap levels select start code and target address low bits
	localparam logic [7:0] STRAP_CODE0 = 8'h50;
	localparam logic [7:0] STRAP_CODE1 = 8'h64;
	localparam logic [7:0] STRAP_CODE2 = 8'h78;
	localparam logic [7:0] STRAP_CODE3 = 8'h8c;
	localparam logic [6:0] TARGET_ADDR_BASE = 7'h40;
	localparam logic [6:0] GENERAL_CALL = 7'h00;
	// Setpoint arithmetic in microvolts
	localparam int BASE_LOW_UV = 400000;
	localparam int BASE_HIGH_UV = 800000;
	localparam int STEP0_UV_X4 = 5;
	localparam int STEP1_UV_X4 = 10;
	localparam int STEP2_UV_X4 = 20;
	localparam int STEP3_UV_X4 = 40;
	localparam int STEP_UNIT_UV = 250;
	localparam logic [6:0] SLEW_CODE0_X4 = 7'h28;
	localparam logic [6:0] SLEW_CODE1_X4 = 7'h14;
	localparam logic [6:0] SLEW_CODE2_X4 = 7'h05;
	localparam logic [6:0] SLEW_CODE3_X4 = 7'h02;
	localparam logic [3:0] SS_CODE0_X2 = 4'h1;
	localparam logic [3:0] SS_CODE1_X2 = 4'h2;
	localparam logic [3:0] SS_CODE2_X2 = 4'h4;
	localparam logic [3:0] SS_CODE3_X2 = 4'h8;
	localparam int STRAP_SETTLE_NS = 400;
	localparam int CLK_NS = 20;
	localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [2:0] {
		BCC_IDLE,
		BCC_ADDR,
		BCC_REG,
		BCC_WDATA,
		BCC_RDATA,
		BCC_SKIP
	} bcc_state_t;
endpackage : bcc_pkg

// ==== bcc_regs_if.sv ====
`timescale 1ns/1ps
interface bcc_regs_if;
	logic wr_stb;
	logic rd_stb;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport link(output wr_stb, output rd_stb, output addr, output wdata, input rdata);
	modport bank(input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface : bcc_regs_if

// ==== bcc_regfile.sv ====
`timescale 1ns/1ps
module bcc_regfile (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic strap_valid,
	input wire logic [7:0] strap_code,
	input wire logic [5:0] event_pulse,
	bcc_regs_if.bank bus,
	output logic [7:0] setpoint_code,
	output logic [7:0] primary_r,
	output logic [7:0] range_r,
	output logic [7:0] aux_r,
	output logic [7:0] flags_r
);
	logic soft_reset;
	logic strap_loaded_r;
	logic [7:0] rdata_r;

	assign soft_reset = bus.wr_stb && bus.addr == bcc_pkg::OFS_PRIMARY
		&& bus.wdata[bcc_pkg::BIT_SOFT_RESET];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			strap_loaded_r <= 1'b0;
			setpoint_code <= 8'h00;
		end else if (strap_valid && (!strap_loaded_r || soft_reset)) begin
			strap_loaded_r <= 1'b1;
			setpoint_code <= strap_code;
		end else if (bus.wr_stb && bus.addr == bcc_pkg::OFS_SETPOINT) begin
			setpoint_code <= bus.wdata;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			primary_r <= bcc_pkg::RST_PRIMARY;
			range_r <= bcc_pkg::RST_RANGE;
			aux_r <= bcc_pkg::RST_AUX;
		end else if (soft_reset) begin
			primary_r <= bcc_pkg::RST_PRIMARY;
			range_r <= bcc_pkg::RST_RANGE;
			aux_r <= bcc_pkg::RST_AUX;
		end else if (bus.wr_stb) begin
			if (bus.addr == bcc_pkg::OFS_PRIMARY)
				primary_r <= bus.wdata & bcc_pkg::MASK_PRIMARY_RD;
			if (bus.addr == bcc_pkg::OFS_RANGE)
				range_r <= bus.wdata & bcc_pkg::MASK_RANGE;
			if (bus.addr == bcc_pkg::OFS_AUX)
				aux_r <= bus.wdata & bcc_pkg::MASK_AUX;
		end
	end

	// New events win over the read clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flags_r <= bcc_pkg::RST_FLAGS;
		end else if (soft_reset) begin
			flags_r <= bcc_pkg::RST_FLAGS | {2'b00, event_pulse};
		end else if (bus.rd_stb && bus.addr == bcc_pkg::OFS_FLAGS) begin
			flags_r <= {2'b00, event_pulse};
		end else begin
			flags_r <= flags_r | {2'b00, event_pulse};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else begin
			unique case (bus.addr)
				bcc_pkg::OFS_SETPOINT: rdata_r <= setpoint_code;
				bcc_pkg::OFS_PRIMARY: rdata_r <= primary_r & bcc_pkg::MASK_PRIMARY_RD;
				bcc_pkg::OFS_RANGE: rdata_r <= range_r;
				bcc_pkg::OFS_AUX: rdata_r <= aux_r;
				bcc_pkg::OFS_FLAGS: rdata_r <= flags_r & bcc_pkg::MASK_FLAGS;
				default: rdata_r <= 8'h00;
			endcase
		end
	end
	assign bus.rdata = rdata_r;

	AST_RD_CLEARS: assert property (@(posedge clock) disable iff (!rst_n)
		bus.rd_stb && bus.addr == bcc_pkg::OFS_FLAGS && event_pulse == 6'h00
		|=> flags_r == 8'h00) else $error("flags not cleared by read");
	AST_EVENT_STICKS: assert property (@(posedge clock) disable iff (!rst_n)
		event_pulse[0] |=> flags_r[0]) else $error("event lost");
	AST_SOFT_RESET: assert property (@(posedge clock) disable iff (!rst_n)
		soft_reset |=> primary_r == bcc_pkg::RST_PRIMARY && range_r == bcc_pkg::RST_RANGE
		&& aux_r == bcc_pkg::RST_AUX) else $error("soft reset missed");
	AST_RSV_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
		range_r[7:4] == 4'h0) else $error("reserved range bits set");
	AST_UNMAPPED: assert property (@(posedge clock) disable iff (!rst_n)
		bus.addr > bcc_pkg::OFS_FLAGS && $stable(bus.addr) |=> bus.rdata == 8'h00)
		else $error("unmapped read nonzero");
endmodule : bcc_regfile

// ==== bcc_top.sv ====
`timescale 1ns/1ps
module bcc_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [1:0] start_voltage_strap,
	input wire logic mode_pin_high,
	input wire logic mode_sync_seen,
	input wire logic [5:0] event_pulse,
	output logic [7:0] setpoint_code,
	output logic [1:0] output_range_select,
	output logic [21:0] setpoint_uv,
	output logic spread_clock_enable,
	output logic switching_enable,
	output logic forced_pulse_width_enable,
	output logic output_discharge_enable,
	output logic fault_retry_enable,
	output logic [1:0] setpoint_slew_rate,
	output logic [6:0] slew_mv_per_us_x4,
	output logic [1:0] soft_start_duration,
	output logic [3:0] soft_start_ms_x2,
	output logic [7:0] aux_control
);
	bcc_regs_if rb();
	logic [7:0] primary_r;
	logic [7:0] range_r;
	logic [7:0] flags_r;
	logic [2:0] scl_sy_r;
	logic [2:0] sda_sy_r;
	logic scl_r;
	logic sda_r;
	logic scl_prev_r;
	logic sda_prev_r;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	bcc_pkg::bcc_state_t state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] reg_ptr_r;
	logic read_dir_r;
	logic ack_phase_r;
	logic wr_pend_r;
	logic [7:0] wbyte_r;
	logic [7:0] tx_r;
	logic sda_drive_r;
	logic [7:0] settle_cnt_r;
	logic strap_valid_r;
	logic [7:0] strap_code_r;
	logic [6:0] target_addr_r;
	logic [1:0] strap_sy0_r;
	logic [1:0] strap_sy1_r;
	logic [1:0] strap_sy2_r;
	logic [2:0] mode_hi_sy_r;
	logic [2:0] mode_clk_sy_r;
	logic mode_hi_r;
	logic mode_clk_r;

	// Three-stage sampling; edges only once stages two and three agree
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			scl_sy_r <= 3'h7;
			sda_sy_r <= 3'h7;
			scl_r <= 1'b1;
			sda_r <= 1'b1;
		end else begin
			scl_sy_r <= {scl_sy_r[1:0], scl_in};
			sda_sy_r <= {sda_sy_r[1:0], sda_in};
			if (scl_sy_r[1] == scl_sy_r[2])
				scl_r <= scl_sy_r[2];
			if (sda_sy_r[1] == sda_sy_r[2])
				sda_r <= sda_sy_r[2];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end else begin
			scl_prev_r <= scl_r;
			sda_prev_r <= sda_r;
		end
	end
	assign scl_rise = scl_r && !scl_prev_r;
	assign scl_fall = !scl_r && scl_prev_r;
	assign start_cond = scl_r && scl_prev_r && sda_prev_r && !sda_r;
	assign stop_cond = scl_r && scl_prev_r && !sda_prev_r && sda_r;

	// Mode pins come from the board; filtered like the bus pins
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_hi_sy_r <= 3'h0;
			mode_clk_sy_r <= 3'h0;
			mode_hi_r <= 1'b0;
			mode_clk_r <= 1'b0;
		end else begin
			mode_hi_sy_r <= {mode_hi_sy_r[1:0], mode_pin_high};
			mode_clk_sy_r <= {mode_clk_sy_r[1:0], mode_sync_seen};
			if (mode_hi_sy_r[1] == mode_hi_sy_r[2])
				mode_hi_r <= mode_hi_sy_r[2];
			if (mode_clk_sy_r[1] == mode_clk_sy_r[2])
				mode_clk_r <= mode_clk_sy_r[2];
		end
	end

	// Strap caught after release, once the pin has settled
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			strap_sy0_r <= 2'b00;
			strap_sy1_r <= 2'b00;
			strap_sy2_r <= 2'b00;
			settle_cnt_r <= 8'h00;
			strap_valid_r <= 1'b0;
			strap_code_r <= 8'h00;
			target_addr_r <= 7'h00;
		end else begin
			strap_sy0_r <= start_voltage_strap;
			strap_sy1_r <= strap_sy0_r;
			strap_sy2_r <= strap_sy1_r;
			if (!strap_valid_r) begin
				// A strap still moving is waited out rather than latched half way
				if (settle_cnt_r == 8'(bcc_pkg::STRAP_SETTLE_CYC)
					&& strap_sy1_r == strap_sy2_r) begin
					strap_valid_r <= 1'b1;
					target_addr_r <= bcc_pkg::TARGET_ADDR_BASE | {5'h00, strap_sy2_r};
					unique case (strap_sy2_r)
						2'b00: strap_code_r <= bcc_pkg::STRAP_CODE0;
						2'b01: strap_code_r <= bcc_pkg::STRAP_CODE1;
						2'b10: strap_code_r <= bcc_pkg::STRAP_CODE2;
						2'b11: strap_code_r <= bcc_pkg::STRAP_CODE3;
					endcase
				end else if (settle_cnt_r != 8'(bcc_pkg::STRAP_SETTLE_CYC)) begin
					settle_cnt_r <= settle_cnt_r + 8'h01;
				end
			end
		end
	end

	// Byte engine: bit_cnt 0..7 data, 8 acknowledge slot
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= bcc_pkg::BCC_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			reg_ptr_r <= 8'h00;
			read_dir_r <= 1'b0;
			ack_phase_r <= 1'b0;
			wr_pend_r <= 1'b0;
			wbyte_r <= 8'h00;
			tx_r <= 8'h00;
			sda_drive_r <= 1'b0;
		end else if (start_cond) begin
			state_r <= bcc_pkg::BCC_ADDR;
			bit_cnt_r <= 4'h0;
			ack_phase_r <= 1'b0;
			wr_pend_r <= 1'b0;
			sda_drive_r <= 1'b0;
		end else if (stop_cond) begin
			state_r <= bcc_pkg::BCC_IDLE;
			sda_drive_r <= 1'b0;
			wr_pend_r <= 1'b0;
		end else if (state_r != bcc_pkg::BCC_IDLE && state_r != bcc_pkg::BCC_SKIP) begin
			if (scl_rise && !ack_phase_r) begin
				shift_r <= {shift_r[6:0], sda_r};
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
			if (scl_rise && ack_phase_r && state_r == bcc_pkg::BCC_RDATA && sda_r)
				state_r <= bcc_pkg::BCC_SKIP;
			if (scl_fall) begin
				if (ack_phase_r) begin
					ack_phase_r <= 1'b0;
					bit_cnt_r <= 4'h0;
					sda_drive_r <= 1'b0;
					if (wr_pend_r)
						wr_pend_r <= 1'b0;
					if (state_r == bcc_pkg::BCC_RDATA) begin
						tx_r <= {rb.rdata[6:0], 1'b0};
						sda_drive_r <= !rb.rdata[7];
						reg_ptr_r <= reg_ptr_r + 8'h01;
					end
				end else if (bit_cnt_r == 4'h8) begin
					ack_phase_r <= 1'b1;
					if (state_r == bcc_pkg::BCC_RDATA) begin
						sda_drive_r <= 1'b0;
					end else begin
						unique case (state_r)
							bcc_pkg::BCC_ADDR: begin
								if (shift_r[7:1] == target_addr_r && strap_valid_r
									&& shift_r[7:1] != bcc_pkg::GENERAL_CALL) begin
									sda_drive_r <= 1'b1;
									read_dir_r <= shift_r[0];
									state_r <= shift_r[0] ? bcc_pkg::BCC_RDATA
										: bcc_pkg::BCC_REG;
								end else begin
									state_r <= bcc_pkg::BCC_SKIP;
								end
							end
							bcc_pkg::BCC_REG: begin
								sda_drive_r <= 1'b1;
								reg_ptr_r <= shift_r;
								state_r <= bcc_pkg::BCC_WDATA;
							end
							bcc_pkg::BCC_WDATA: begin
								sda_drive_r <= 1'b1;
								wbyte_r <= shift_r;
								wr_pend_r <= 1'b1;
							end
							default: state_r <= bcc_pkg::BCC_SKIP;
						endcase
					end
				end else if (state_r == bcc_pkg::BCC_RDATA && bit_cnt_r != 4'h0) begin
					sda_drive_r <= !tx_r[7];
					tx_r <= {tx_r[6:0], 1'b0};
				end
			end
			// First read bit appears after the address acknowledge
			if (scl_fall && ack_phase_r && state_r == bcc_pkg::BCC_ADDR && read_dir_r) begin
				tx_r <= {rb.rdata[6:0], 1'b0};
				sda_drive_r <= !rb.rdata[7];
			end
		end
	end

	// Write lands when SCL falls ending the data acknowledge
	assign rb.wr_stb = wr_pend_r && ack_phase_r && scl_fall && !start_cond && !stop_cond;
	assign rb.rd_stb = state_r == bcc_pkg::BCC_RDATA && ack_phase_r && scl_fall
		&& !start_cond && !stop_cond;
	assign rb.addr = (state_r == bcc_pkg::BCC_WDATA) ? reg_ptr_r : reg_ptr_r;
	assign rb.wdata = wbyte_r;
	assign sda_out = 1'b0;
	assign sda_oe = sda_drive_r;

	bcc_regfile u_regs (
		.clock(clock),
		.rst_n(rst_n),
		.strap_valid(strap_valid_r),
		.strap_code(strap_code_r),
		.event_pulse(event_pulse),
		.bus(rb),
		.setpoint_code(setpoint_code),
		.primary_r(primary_r),
		.range_r(range_r),
		.aux_r(aux_control),
		.flags_r(flags_r)
	);

	assign spread_clock_enable = primary_r[bcc_pkg::BIT_SPREAD];
	assign switching_enable = primary_r[bcc_pkg::BIT_SWITCH];
	assign forced_pulse_width_enable = primary_r[bcc_pkg::BIT_FPWM] || mode_hi_r
		|| mode_clk_r;
	assign output_discharge_enable = primary_r[bcc_pkg::BIT_DISCH];
	assign fault_retry_enable = primary_r[bcc_pkg::BIT_RETRY];
	assign setpoint_slew_rate = primary_r[bcc_pkg::BIT_RAMP_LO +: 2];
	assign output_range_select = range_r[bcc_pkg::BIT_RANGE_LO +: 2];
	assign soft_start_duration = range_r[bcc_pkg::BIT_SS_LO +: 2];

	always_comb begin
		unique case (setpoint_slew_rate)
			2'b00: slew_mv_per_us_x4 = bcc_pkg::SLEW_CODE0_X4;
			2'b01: slew_mv_per_us_x4 = bcc_pkg::SLEW_CODE1_X4;
			2'b10: slew_mv_per_us_x4 = bcc_pkg::SLEW_CODE2_X4;
			2'b11: slew_mv_per_us_x4 = bcc_pkg::SLEW_CODE3_X4;
		endcase
	end

	always_comb begin
		unique case (soft_start_duration)
			2'b00: soft_start_ms_x2 = bcc_pkg::SS_CODE0_X2;
			2'b01: soft_start_ms_x2 = bcc_pkg::SS_CODE1_X2;
			2'b10: soft_start_ms_x2 = bcc_pkg::SS_CODE2_X2;
			2'b11: soft_start_ms_x2 = bcc_pkg::SS_CODE3_X2;
		endcase
	end

	always_comb begin
		unique case (output_range_select)
			2'b00: setpoint_uv = 22'(bcc_pkg::BASE_LOW_UV
				+ int'(setpoint_code) * bcc_pkg::STEP0_UV_X4 * bcc_pkg::STEP_UNIT_UV);
			2'b01: setpoint_uv = 22'(bcc_pkg::BASE_LOW_UV
				+ int'(setpoint_code) * bcc_pkg::STEP1_UV_X4 * bcc_pkg::STEP_UNIT_UV);
			2'b10: setpoint_uv = 22'(bcc_pkg::BASE_LOW_UV
				+ int'(setpoint_code) * bcc_pkg::STEP2_UV_X4 * bcc_pkg::STEP_UNIT_UV);
			2'b11: setpoint_uv = 22'(bcc_pkg::BASE_HIGH_UV
				+ int'(setpoint_code) * bcc_pkg::STEP3_UV_X4 * bcc_pkg::STEP_UNIT_UV);
		endcase
	end

	AST_WRITE_ON_ACK_FALL: assert property (@(posedge clock) disable iff (!rst_n)
		rb.wr_stb |-> scl_fall && ack_phase_r && state_r == bcc_pkg::BCC_WDATA)
		else $error("write outside data acknowledge");
	AST_NO_GENERAL_CALL: assert property (@(posedge clock) disable iff (!rst_n)
		state_r == bcc_pkg::BCC_ADDR && scl_fall && bit_cnt_r == 4'h8
		&& shift_r[7:1] == bcc_pkg::GENERAL_CALL |=> !sda_drive_r)
		else $error("general call acknowledged");
	AST_FPWM_OR: assert property (@(posedge clock) disable iff (!rst_n)
		$past(mode_pin_high, 4) && $past(mode_pin_high, 3) |-> forced_pulse_width_enable)
		else $error("mode pin ignored");
	AST_RANGE4: assert property (@(posedge clock) disable iff (!rst_n)
		output_range_select == 2'b11
		|-> int'(setpoint_uv) == 800000 + 10000 * int'(setpoint_code))
		else $error("range four setpoint wrong");
	AST_RANGE1: assert property (@(posedge clock) disable iff (!rst_n)
		output_range_select == 2'b00
		|-> int'(setpoint_uv) == 400000 + 1250 * int'(setpoint_code))
		else $error("range one setpoint wrong");
	AST_SWITCH_RST: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(strap_valid_r) |-> switching_enable && output_discharge_enable
		&& !spread_clock_enable) else $error("primary control reset wrong");
	AST_STRAP_SETPOINT: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(strap_valid_r) |=> setpoint_code == strap_code_r)
		else $error("setpoint not loaded from strap");
	AST_SDA_ON_FALL: assert property (@(posedge clock) disable iff (!rst_n)
		$changed(sda_drive_r) |-> $past(scl_fall) || $past(start_cond) || $past(stop_cond))
		else $error("data line moved while clock high");
	AST_SOFT_START_RST: assert property (@(posedge clock) disable iff (!rst_n)
		soft_start_duration == 2'b01 |-> soft_start_ms_x2 == 4'h2)
		else $error("soft start time wrong");
endmodule : bcc_top

// ==== bcc_i2c_host.sv ====
`timescale 1ns/1ps
module bcc_i2c_host #(
	parameter int QTR = 8
) (
	input wire logic clock,
	output logic scl,
	output logic sda_low,
	input wire logic sda_line
);
	logic [7:0] rd [0:7];
	event ack_due;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tq;
		repeat (QTR) @(negedge clock);
	endtask : tq
	// SDA moves only while SCL is low, so no false START or STOP
	task automatic bit_io(input logic b, input logic mark, output logic r);
		sda_low = !b;
		tq;
		scl = 1'b1;
		tq;
		r = sda_line;
		tq;
		if (mark) begin
			-> ack_due;
		end
		scl = 1'b0;
		tq;
	endtask : bit_io
	task automatic start_c;
		sda_low = 1'b1;
		tq;
		scl = 1'b0;
		tq;
	endtask : start_c
	task automatic stop_c;
		sda_low = 1'b1;
		tq;
		scl = 1'b1;
		tq;
		sda_low = 1'b0;
		tq;
	endtask : stop_c
	task automatic byte_tx(input logic [7:0] d, input logic mark, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], 1'b0, r);
		end
		bit_io(1'b1, mark, r);
		ack = !r;
	endtask : byte_tx
	task automatic byte_rx(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, 1'b0, d[i]);
		end
		bit_io(last, 1'b0, r);
	endtask : byte_rx
	// Frame abandoned after an address NACK, as the bus requires
	task automatic write_reg(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d,
			output logic ok);
		logic k1, k2, k3;
		k2 = 1'b0;
		k3 = 1'b0;
		start_c;
		byte_tx({a, 1'b0}, 1'b0, k1);
		if (k1) begin
			byte_tx(ofs, 1'b0, k2);
			byte_tx(d, 1'b1, k3);
		end
		stop_c;
		ok = k1 && k2 && k3;
	endtask : write_reg
	task automatic read_regs(input logic [6:0] a, input logic [7:0] ofs, input int n,
			output logic ok);
		logic k1, k2, k3;
		k2 = 1'b0;
		start_c;
		byte_tx({a, 1'b0}, 1'b0, k1);
		if (k1) begin
			byte_tx(ofs, 1'b0, k2);
		end
		stop_c;
		start_c;
		byte_tx({a, 1'b1}, 1'b0, k3);
		if (k3) begin
			for (int i = 0; i < n; i++) begin
				byte_rx(i == n - 1, rd[i]);
			end
		end
		stop_c;
		ok = k1 && k2 && k3;
	endtask : read_regs
endmodule : bcc_i2c_host

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	logic clock, rst_n, scl, sda_low, sda_line, sda_out, sda_oe, mode_pin_high, mode_sync_seen;
	logic spread_clock_enable, switching_enable, forced_pulse_width_enable;
	logic output_discharge_enable, fault_retry_enable, ok_t;
	logic [1:0] start_voltage_strap, output_range_select, setpoint_slew_rate, soft_start_duration;
	logic [5:0] event_pulse;
	logic [6:0] dev_addr, slew_mv_per_us_x4;
	logic [7:0] setpoint_code, aux_control, d;
	logic [3:0] soft_start_ms_x2;
	logic [21:0] setpoint_uv;
	logic [7:0] exp_rst [0:7];
	int errors, total_checks;
	int uv_max [0:3] = '{718750, 1037500, 1675000, 3350000};
	int slew_x4 [0:3] = '{40, 20, 5, 2};
	// Open-drain SDA with pull-up
	assign sda_line = !sda_low && !(sda_oe && !sda_out);
	bcc_top u_bcc_top (.clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .start_voltage_strap(start_voltage_strap),
		.mode_pin_high(mode_pin_high), .mode_sync_seen(mode_sync_seen),
		.event_pulse(event_pulse), .setpoint_code(setpoint_code),
		.output_range_select(output_range_select), .setpoint_uv(setpoint_uv),
		.spread_clock_enable(spread_clock_enable), .switching_enable(switching_enable),
		.forced_pulse_width_enable(forced_pulse_width_enable),
		.output_discharge_enable(output_discharge_enable),
		.fault_retry_enable(fault_retry_enable), .setpoint_slew_rate(setpoint_slew_rate),
		.slew_mv_per_us_x4(slew_mv_per_us_x4), .soft_start_duration(soft_start_duration),
		.soft_start_ms_x2(soft_start_ms_x2), .aux_control(aux_control));
	bcc_i2c_host u_bcc_i2c_host (.clock(clock), .scl(scl), .sda_low(sda_low),
		.sda_line(sda_line));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic end_sim;
		if (errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic do_reset;
		rst_n = 1'b0;
		repeat (12) @(negedge clock);
		rst_n = 1'b1;
		// Strap capture and address enable need about 22 cycles
		repeat (40) @(negedge clock);
	endtask : do_reset
	task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
		logic ok;
		u_bcc_i2c_host.write_reg(dev_addr, ofs, v, ok);
		chk("write ack", 1, ok);
	endtask : wr
	task automatic rd(input logic [7:0] ofs, input int n);
		logic ok;
		u_bcc_i2c_host.read_regs(dev_addr, ofs, n, ok);
		chk("read ack", 1, ok);
	endtask : rd
	task automatic rd1(input logic [7:0] ofs, input logic [7:0] exp, input string what);
		rd(ofs, 1);
		chk(what, exp, u_bcc_i2c_host.rd[0]);
	endtask : rd1
	// About 38k cycles of traffic expected
	initial begin
		repeat (90000) @(posedge clock);
		errors++;
		end_sim;
	end
	initial begin
		rst_n = 1'b0;
		start_voltage_strap = 2'd2;
		mode_pin_high = 1'b0;
		mode_sync_seen = 1'b0;
		event_pulse = 6'h00;
		dev_addr = 7'h42;
		errors = 0;
		total_checks = 0;
		exp_rst = '{bcc_pkg::STRAP_CODE2, 8'h2a, 8'h09, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
		do_reset;
		chk("switching", 1, switching_enable);
		chk("discharge", 1, output_discharge_enable);
		chk("spread", 0, spread_clock_enable);
		chk("slew rate", 5, slew_mv_per_us_x4);
		chk("range sel", 2, output_range_select);
		chk("soft start", 2, soft_start_ms_x2);
		chk("setpoint uv", 400000 + 5000 * int'(bcc_pkg::STRAP_CODE2), setpoint_uv);
		rd(8'h00, 8);
		for (int i = 0; i < 8; i++) begin
			chk("reset value", exp_rst[i], u_bcc_i2c_host.rd[i]);
		end
		rd1(8'h04, 8'h00, "flags after read");
		event_pulse = 6'h29;
		@(negedge clock);
		event_pulse = 6'h00;
		rd1(8'h04, 8'h29, "flags event");
		rd1(8'h04, 8'h00, "flags cleared");
		rd1(8'h09, 8'h00, "unmapped");
		fork
			wr(8'h00, 8'hff);
			begin
				@(u_bcc_i2c_host.ack_due);
				chk("setpoint before ack fall", bcc_pkg::STRAP_CODE2, setpoint_code);
			end
		join
		chk("setpoint code", 8'hff, setpoint_code);
		for (int r = 0; r < 4; r++) begin
			wr(8'h02, {4'h0, r[1:0], r[1:0]});
			chk("range sel", r, output_range_select);
			chk("soft start", 1 << r, soft_start_ms_x2);
			chk("setpoint uv", uv_max[r], setpoint_uv);
			rd1(8'h02, {4'h0, r[1:0], r[1:0]}, "range reg");
		end
		for (int k = 0; k < 4; k++) begin
			d = {1'b0, k[0], ~k[0], k[1], ~k[1], k[0] ^ k[1], k[1:0]};
			wr(8'h01, d);
			chk("spread", d[6], spread_clock_enable);
			chk("switching", d[5], switching_enable);
			chk("forced pwm", d[4], forced_pulse_width_enable);
			chk("discharge", d[3], output_discharge_enable);
			chk("retry", d[2], fault_retry_enable);
			chk("slew code", k, setpoint_slew_rate);
			chk("slew rate", slew_x4[k], slew_mv_per_us_x4);
			rd(8'h00, 2);
			chk("setpoint kept", 8'hff, u_bcc_i2c_host.rd[0]);
			chk("primary read", d, u_bcc_i2c_host.rd[1]);
		end
		wr(8'h01, 8'h2a);
		for (int m = 0; m < 4; m++) begin
			{mode_pin_high, mode_sync_seen} = m[1:0];
			// Pin filter takes four clocks
			repeat (6) @(negedge clock);
			chk("forced pwm by pin", m != 0, forced_pulse_width_enable);
		end
		{mode_pin_high, mode_sync_seen} = 2'b00;
		wr(8'h03, 8'h03);
		chk("aux out", 8'h03, aux_control);
		rd1(8'h03, 8'h03, "aux reg");
		for (int j = 0; j < 2; j++) begin
			u_bcc_i2c_host.write_reg(j == 0 ? 7'h43 : 7'h00, 8'h00, 8'h11, ok_t);
			chk("ack refused", 0, ok_t);
		end
		rd1(8'h00, 8'hff, "setpoint after refusal");
		wr(8'h01, 8'h80);
		repeat (60) @(negedge clock);
		rd(8'h00, 8);
		for (int i = 0; i < 8; i++) begin
			chk("soft reset value", exp_rst[i], u_bcc_i2c_host.rd[i]);
		end
		start_voltage_strap = 2'd1;
		dev_addr = 7'h41;
		do_reset;
		rd1(8'h00, bcc_pkg::STRAP_CODE1, "strap setpoint");
		u_bcc_i2c_host.write_reg(7'h42, 8'h00, 8'h11, ok_t);
		chk("old address", 0, ok_t);
		end_sim;
	end
endmodule : tb_top
